// [bench/onoff_sva.sv]
// Port assertions for the on/off switch controller
`timescale 1ns/1ns
module onoff_sva
  import onoff_pkg::*;
(
  // Clock, reset and pins
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  input wire logic FB_OVER_CURRENT_I,
  input wire logic CUR_LIMIT_I,
  input wire logic SUPPLY_LOW_I,
  input wire logic SUPPLY_OK_I,
  input wire logic TEMP_HOT_I,
  input wire logic TEMP_COOLED_I,
  input wire logic SWITCH_ON_O,
  input wire logic CHARGE_EN_O,
  // Bus handshakes
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic BVALID_O,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic RVALID_O
);
  logic [11:0] gap_r, gap_nxt, on_r, on_nxt;
  logic [3:0]  fbh_r, fbh_nxt;
  logic        uv_r, uv_nxt, ot_r, ot_nxt;

  always_comb begin
    gap_nxt = SWITCH_ON_O ? 12'h000 : gap_r + 12'(gap_r != 12'hFFF);
    on_nxt  = SWITCH_ON_O ? on_r + 12'h001 : 12'h000;
    fbh_nxt = FB_OVER_CURRENT_I ? fbh_r + 4'(fbh_r != 4'hF) : 4'h0;
    uv_nxt  = SUPPLY_LOW_I || (uv_r && !SUPPLY_OK_I);
    ot_nxt  = TEMP_HOT_I || (ot_r && !TEMP_COOLED_I);
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      gap_r <= 12'hFFF;
      on_r  <= 12'h000;
      fbh_r <= 4'h0;
      uv_r  <= 1'b1;
      ot_r  <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      on_r  <= on_nxt;
      fbh_r <= fbh_nxt;
      uv_r  <= uv_nxt;
      ot_r  <= ot_nxt;
    end
  end

  default clocking dck @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_charge_off: assert property (CHARGE_EN_O == !SWITCH_ON_O)
    else $error("charge enable while switch on");
  a_blank_hold: assert property ($rose(SWITCH_ON_O) ##0
    (!SUPPLY_LOW_I && !TEMP_HOT_I)[*8] |-> SWITCH_ON_O)
    else $error("pulse ended inside blanking");
  a_limit_off: assert property (SWITCH_ON_O && on_r > 12'h01E
    && CUR_LIMIT_I |-> ##[1:4] !SWITCH_ON_O)
    else $error("current limit did not end pulse");
  a_one_pulse: assert property ($rose(SWITCH_ON_O) |-> gap_r > 12'h1F4)
    else $error("second pulse in one cycle");
  a_max_window: assert property (on_r < 12'h500)
    else $error("pulse longer than duty window");
  a_prot_block: assert property ((uv_r || ot_r)
    && $past(uv_r || ot_r, 4) |-> !SWITCH_ON_O)
    else $error("switching while protection active");
  a_fb_skip: assert property ($rose(SWITCH_ON_O) |-> fbh_r < 4'h6)
    else $error("pulse while feedback disabled");
  a_wr_answer: assert property (AWVALID_I && AWREADY_O && WVALID_I
    && WREADY_O |-> ##2 BVALID_O)
    else $error("write response late");
  a_rd_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("read data late");
endmodule

bind onoff_switch_controller onoff_sva onoff_sva_inst (
  .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I),
  .FB_OVER_CURRENT_I(FB_OVER_CURRENT_I), .CUR_LIMIT_I(CUR_LIMIT_I),
  .SUPPLY_LOW_I(SUPPLY_LOW_I), .SUPPLY_OK_I(SUPPLY_OK_I),
  .TEMP_HOT_I(TEMP_HOT_I), .TEMP_COOLED_I(TEMP_COOLED_I),
  .SWITCH_ON_O(SWITCH_ON_O), .CHARGE_EN_O(CHARGE_EN_O),
  .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I),
  .WREADY_O(WREADY_O), .BVALID_O(BVALID_O), .ARVALID_I(ARVALID_I),
  .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O)
);

// [bench/power_stage_model.sv]
// Power stage model giving the switch current limit signal
`timescale 1ns/1ns
module power_stage_model (
  // Clock and switch drive
  input  wire logic        clk_i,
  input  wire logic        sw_i,
  // Load behaviour
  input  wire logic        spike_i,
  input  wire logic [11:0] dly_i,
  // Current limit comparator
  output logic             cur_lim_o
);
  logic [11:0] cnt_r, cnt_nxt;

  always_comb cnt_nxt = sw_i ? cnt_r + 12'h001 : 12'h000;
  always_ff @(posedge clk_i) cnt_r <= cnt_nxt;
  // Turn-on spike, then a ramp reaching the limit after dly_i cycles
  assign cur_lim_o = sw_i && ((spike_i && cnt_r < 12'h004) ||
                     (dly_i != 12'h000 && cnt_r >= dly_i));
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the on/off switch controller
`timescale 1ns/1ns
`include "onoff_regs.svh"
module tb_top
  import onoff_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, fb = 1'b0, low = 1'b0, ok = 1'b1;
  logic        hot = 1'b0, cool = 1'b0, spike = 1'b0, awv = 1'b0;
  logic        wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic        lim, sw, chg, awr, wr, bv, arr, rv;
  logic [7:0]  aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [11:0] dly = 12'h000;
  axi_resp_t   bresp, rresp;
  int          fail_count = 0, compares = 0;

  always #4 clk = ~clk;

  onoff_switch_controller #(.FAULT_CYCLES(4), .OFF_CYCLES(6))
    onoff_switch_controller_inst (
    .MCLK_I(clk), .RESET_N_I(rst_n), .FB_OVER_CURRENT_I(fb),
    .CUR_LIMIT_I(lim), .SUPPLY_LOW_I(low), .SUPPLY_OK_I(ok),
    .TEMP_HOT_I(hot), .TEMP_COOLED_I(cool), .SWITCH_ON_O(sw),
    .CHARGE_EN_O(chg), .AWADDR_I(aw), .AWVALID_I(awv), .AWREADY_O(awr),
    .WDATA_I(wd), .WSTRB_I(4'hF), .WVALID_I(wv), .WREADY_O(wr),
    .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(bry), .ARADDR_I(ar),
    .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rd), .RRESP_O(rresp),
    .RVALID_O(rv), .RREADY_I(rry));

  power_stage_model power_stage_model_inst (.clk_i(clk), .sw_i(sw),
    .spike_i(spike), .dly_i(dly), .cur_lim_o(lim));

  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tmo(input int n, lim_n);
    if (n >= lim_n) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input axi_resp_t r);
    int n;
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    tmo(n, 100);
    bry <= 1'b0;
    chk("bresp", 32'(bresp), 32'(r));
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] e,
                     input axi_resp_t r, input logic [31:0] m);
    int n;
    ar <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    tmo(n, 100);
    rry <= 1'b0;
    chk("rresp", 32'(rresp), 32'(r));
    chk("rdata", rd & m, e);
  endtask

  // Waits for a pulse, optionally disables feedback at its start
  task automatic pulse(input int lim_n, input bit dis, output int w, len);
    len = 0;
    for (w = 0; w < lim_n && sw !== 1'b1; w++) @(posedge clk);
    if (w < lim_n && dis) fb <= 1'b1;
    while (w < lim_n && sw === 1'b1 && len < 2000) begin
      @(posedge clk);
      len++;
    end
  endtask

  task automatic t_regs();
    axr(`CTRL_OFS, 32'h1, `RESP_OKAY, 32'hFFFFFFFF);
    axw(`CTRL_OFS, 32'h0, `RESP_OKAY);
    axr(`CTRL_OFS, 32'h0, `RESP_OKAY, 32'hFFFFFFFF);
    axw(`CTRL_OFS, 32'h1, `RESP_OKAY);
    axw(`STAT_OFS, 32'h1F, `RESP_OKAY);
    axr(`STAT_OFS, 32'h0, `RESP_OKAY, 32'hFFFFFFEF);
    axw(8'h08, 32'h1, `RESP_SLVERR);
    axr(8'h08, 32'h0, `RESP_SLVERR, 32'hFFFFFFFF);
  endtask

  task automatic t_pulse();
    int w, len;
    dly <= 12'h028;
    pulse(4000, 1'b1, w, len);
    chk("limit_len", 32'(len > 40 && len < 47), 32'h1);
    pulse(4000, 1'b0, w, len);
    chk("skip_len", 32'(len), 32'h0);
  endtask

  task automatic t_window();
    int w, len;
    spike <= 1'b1;
    dly <= 12'h000;
    fb <= 1'b0;
    pulse(4000, 1'b1, w, len);
    chk("window_len", 32'(len > 1189 && len < 1276), 32'h1);
    spike <= 1'b0;
    dly <= 12'h028;
  endtask

  task automatic t_prot(input bit ot);
    int w, len;
    {hot, cool, low, ok} <= ot ? 4'b1001 : 4'b0010;
    fb <= 1'b0;
    pulse(4000, 1'b0, w, len);
    chk("blocked", 32'(len), 32'h0);
    axr(`STAT_OFS, ot ? 32'h4 : 32'h2, `RESP_OKAY, 32'h6);
    {hot, low} <= 2'b00;
    pulse(4000, 1'b0, w, len);
    chk("hysteresis", 32'(len), 32'h0);
    {cool, ok} <= 2'b11;
    pulse(16000, 1'b1, w, len);
    chk("recover", 32'(len > 0), 32'h1);
  endtask

  task automatic t_restart();
    int w, len, n;
    pulse(4000, 1'b0, w, len);
    chk("fb_clear", 32'(len), 32'h0);
    fb <= 1'b0;
    n = 0;
    do begin
      pulse(4000, 1'b0, w, len);
      n += int'(len > 0);
    end while (len > 0 && n < 9);
    chk("burst", 32'(n), 32'h4);
    axr(`STAT_OFS, 32'h8, `RESP_OKAY, 32'h9);
    pulse(16000, 1'b1, w, len);
    chk("off_time", 32'(w > 5190 && w < 11624 && len > 0), 32'h1);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_pulse();
    t_window();
    t_prot(1'b0);
    t_prot(1'b1);
    t_restart();
    tally_and_finish();
  end
endmodule

// [rtl/jitter_osc.sv]
// Jittered switching oscillator with max duty window
`timescale 1ns/1ns
`include "onoff_regs.svh"
module jitter_osc
  import onoff_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Oscillator outputs
  osc_if.osc        osc
);

  period_t cnt_r, cnt_nxt;
  period_t per_r, per_nxt;
  logic    up_r, up_nxt;
  logic    start_r, start_nxt;
  logic    win_r, win_nxt;
  period_t duty_lim;

  // ****************************************************************
  // Period counter and triangular dither
  // ****************************************************************
  always_comb begin
    duty_lim  = period_t'((22'(per_r) * 22'(`DUTY_PCT)) / 22'd100);
    cnt_nxt   = cnt_r + 11'h001;
    per_nxt   = per_r;
    up_nxt    = up_r;
    start_nxt = 1'b0;
    if (cnt_r >= per_r - 11'h001) begin
      cnt_nxt   = 11'h000;
      start_nxt = 1'b1;
      if (up_r) begin
        per_nxt = per_r + period_t'(`JIT_STEP);
        if (per_nxt >= period_t'(`PER_MAX)) begin
          up_nxt = 1'b0;
        end
      end else begin
        per_nxt = per_r - period_t'(`JIT_STEP);
        if (per_nxt <= period_t'(`PER_MIN)) begin
          up_nxt = 1'b1;
        end
      end
    end
    win_nxt = (cnt_nxt < duty_lim);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_r   <= 11'h000;
      per_r   <= period_t'(`PER_MIN);
      up_r    <= 1'b1;
      start_r <= 1'b0;
      win_r   <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      per_r   <= per_nxt;
      up_r    <= up_nxt;
      start_r <= start_nxt;
      win_r   <= win_nxt;
    end
  end

  assign osc.cycle_start     = start_r;
  assign osc.max_duty_window = win_r;

endmodule

// [rtl/onoff_pkg.sv]
// Types for the on/off switch controller
package onoff_pkg;
  typedef enum logic [1:0] {SW_OFF, SW_BLANK, SW_ON} sw_state_t;
  typedef logic [1:0]  axi_resp_t;
  typedef logic [10:0] period_t;
endpackage

// [rtl/onoff_regs.svh]
// Constants for the on/off switch controller
`ifndef ONOFF_REGS_SVH
`define ONOFF_REGS_SVH

// ****************************************************************
// Clock and oscillator timing
// ****************************************************************
`define CLK_HZ      125000000
`define CLK_NS      8
`define OSC_HZ      66000
`define JIT_PP_HZ   4000
`define JIT_MOD_HZ  1000
`define PER_MIN     (`CLK_HZ / (`OSC_HZ + `JIT_PP_HZ / 2))
`define PER_MAX     (`CLK_HZ / (`OSC_HZ - `JIT_PP_HZ / 2))
`define JIT_HALF    (`OSC_HZ / (2 * `JIT_MOD_HZ))
`define JIT_STEP    ((`PER_MAX - `PER_MIN) / `JIT_HALF)
`define DUTY_PCT    65
`define LEB_NS      200
`define LEB_CYC     ((`LEB_NS + `CLK_NS - 1) / `CLK_NS)
`define FAULT_MS    50
`define OFF_MS      800
`define FAULT_CYC   (`FAULT_MS * `OSC_HZ / 1000)
`define OFF_CYC     (`OFF_MS * `OSC_HZ / 1000)

// ****************************************************************
// Register map
// ****************************************************************
`define CTRL_OFS    8'h00
`define STAT_OFS    8'h04
`define CTRL_AR_BIT 0
`define CTRL_RST    1'b1
`define STAT_SW     0
`define STAT_UV     1
`define STAT_OT     2
`define STAT_AROFF  3
`define STAT_EN     4
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/onoff_switch_controller.sv]
// On/off cycle-skipping switch controller with register slave
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "onoff_regs.svh"
module onoff_switch_controller
  import onoff_pkg::*;
#(
  parameter bit          HAS_AUTORESTART = 1'b1,
  parameter int unsigned FAULT_CYCLES    = `FAULT_CYC,
  parameter int unsigned OFF_CYCLES      = `OFF_CYC
)(
  // Clock and reset
  input  wire logic       MCLK_I,
  input  wire logic       RESET_N_I,
  // Analog comparator conditions
  input  wire logic       FB_OVER_CURRENT_I,
  input  wire logic       CUR_LIMIT_I,
  input  wire logic       SUPPLY_LOW_I,
  input  wire logic       SUPPLY_OK_I,
  input  wire logic       TEMP_HOT_I,
  input  wire logic       TEMP_COOLED_I,
  // Power stage
  output logic            SWITCH_ON_O,
  output logic            CHARGE_EN_O,
  // AXI4-Lite write
  input  wire logic [7:0] AWADDR_I,
  input  wire logic       AWVALID_I,
  output logic            AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0] WSTRB_I,
  input  wire logic       WVALID_I,
  output logic            WREADY_O,
  output axi_resp_t       BRESP_O,
  output logic            BVALID_O,
  input  wire logic       BREADY_I,
  // AXI4-Lite read
  input  wire logic [7:0] ARADDR_I,
  input  wire logic       ARVALID_I,
  output logic            ARREADY_O,
  output logic [31:0]     RDATA_O,
  output axi_resp_t       RRESP_O,
  output logic            RVALID_O,
  input  wire logic       RREADY_I
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [5:0] meta_r;
  logic [5:0] sync_r;
  logic       fb_en_s;
  logic       cur_lim_s;
  logic       sup_low_s;
  logic       sup_ok_s;
  logic       hot_s;
  logic       cooled_s;

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      meta_r <= 6'h00;
      sync_r <= 6'h00;
    end else begin
      meta_r <= {FB_OVER_CURRENT_I, CUR_LIMIT_I, SUPPLY_LOW_I,
                 SUPPLY_OK_I, TEMP_HOT_I, TEMP_COOLED_I};
      sync_r <= meta_r;
    end
  end

  assign fb_en_s   = ~sync_r[5];
  assign cur_lim_s = sync_r[4];
  assign sup_low_s = sync_r[3];
  assign sup_ok_s  = sync_r[2];
  assign hot_s     = sync_r[1];
  assign cooled_s  = sync_r[0];

  // ****************************************************************
  // Oscillator
  // ****************************************************************
  osc_if osc ();

  jitter_osc u_osc (
    .clk_i     (MCLK_I),
    .reset_n_i (RESET_N_I),
    .osc       (osc.osc)
  );

  // ****************************************************************
  // Protection latches and auto-restart
  // ****************************************************************
  logic        uv_r, uv_nxt;
  logic        ot_r, ot_nxt;
  logic        ar_off_r, ar_off_nxt;
  logic [15:0] fault_r, fault_nxt;
  logic [15:0] off_r, off_nxt;
  logic        ar_en_r;
  logic        en_smp_r, en_smp_nxt;
  logic        permit;

  always_comb begin
    uv_nxt     = uv_r;
    ot_nxt     = ot_r;
    ar_off_nxt = ar_off_r;
    fault_nxt  = fault_r;
    off_nxt    = off_r;
    if (sup_low_s) begin
      uv_nxt = 1'b1;
    end else if (sup_ok_s) begin
      uv_nxt = 1'b0;
    end
    if (hot_s) begin
      ot_nxt = 1'b1;
    end else if (cooled_s) begin
      ot_nxt = 1'b0;
    end
    if (!HAS_AUTORESTART || !ar_en_r || uv_r) begin
      ar_off_nxt = 1'b0;
      fault_nxt  = 16'h0000;
      off_nxt    = 16'h0000;
    end else if (osc.cycle_start) begin
      if (ar_off_r) begin
        off_nxt = off_r + 16'h0001;
        if (off_r >= 16'(OFF_CYCLES - 1)) begin
          ar_off_nxt = 1'b0;
          off_nxt    = 16'h0000;
          fault_nxt  = 16'h0000;
        end
      end else if (!fb_en_s) begin
        fault_nxt = 16'h0000;
      end else if (fault_r >= 16'(FAULT_CYCLES)) begin
        ar_off_nxt = 1'b1;
        fault_nxt  = 16'h0000;
      end else begin
        fault_nxt = fault_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      uv_r     <= 1'b1;
      ot_r     <= 1'b0;
      ar_off_r <= 1'b0;
      fault_r  <= 16'h0000;
      off_r    <= 16'h0000;
    end else begin
      uv_r     <= uv_nxt;
      ot_r     <= ot_nxt;
      ar_off_r <= ar_off_nxt;
      fault_r  <= fault_nxt;
      off_r    <= off_nxt;
    end
  end

  assign permit = ~uv_r & ~ot_r & ~ar_off_r;

  // ****************************************************************
  // Switch state machine
  // ****************************************************************
  sw_state_t  st_r, st_nxt;
  logic [7:0] blank_r, blank_nxt;
  logic       sw_r, sw_nxt;

  always_comb begin
    st_nxt     = st_r;
    blank_nxt  = blank_r;
    en_smp_nxt = en_smp_r;
    if (osc.cycle_start) begin
      en_smp_nxt = fb_en_s;
    end
    case (st_r)
      SW_OFF: begin
        if (osc.cycle_start && fb_en_s && !uv_r && !ot_r
            && !ar_off_nxt) begin
          st_nxt    = SW_BLANK;
          blank_nxt = 8'h00;
        end
      end
      SW_BLANK: begin
        blank_nxt = blank_r + 8'h01;
        if (!osc.max_duty_window || !permit) begin
          st_nxt = SW_OFF;
        end else if (blank_r >= 8'(`LEB_CYC - 1)) begin
          st_nxt = SW_ON;
        end
      end
      SW_ON: begin
        if (cur_lim_s || !osc.max_duty_window || !permit) begin
          st_nxt = SW_OFF;
        end
      end
      default: begin
        st_nxt = SW_OFF;
      end
    endcase
    sw_nxt = (st_nxt != SW_OFF);
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      st_r     <= SW_OFF;
      blank_r  <= 8'h00;
      sw_r     <= 1'b0;
      en_smp_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      blank_r  <= blank_nxt;
      sw_r     <= sw_nxt;
      en_smp_r <= en_smp_nxt;
    end
  end

  assign SWITCH_ON_O = sw_r;
  assign CHARGE_EN_O = ~sw_r;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic        awrdy_r, awrdy_nxt;
  logic        wrdy_r, wrdy_nxt;
  logic        aw_hold_r, aw_hold_nxt;
  logic        w_hold_r, w_hold_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic        w_strb_r, w_strb_nxt;
  logic        bvalid_r, bvalid_nxt;
  axi_resp_t   bresp_r, bresp_nxt;
  logic        arrdy_r, arrdy_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  axi_resp_t   rresp_r, rresp_nxt;
  logic        ar_en_nxt;
  logic [31:0] stat_word;

  always_comb begin
    stat_word = 32'h00000000;
    stat_word[`STAT_SW]    = sw_r;
    stat_word[`STAT_UV]    = uv_r;
    stat_word[`STAT_OT]    = ot_r;
    stat_word[`STAT_AROFF] = ar_off_r;
    stat_word[`STAT_EN]    = en_smp_r;
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    ar_en_nxt   = ar_en_r;
    if (AWVALID_I && awrdy_r) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = AWADDR_I;
    end
    if (WVALID_I && wrdy_r) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = WDATA_I;
      w_strb_nxt = WSTRB_I[0];
    end
    if (bvalid_r && BREADY_I) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_hold_r && w_hold_r && !bvalid_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = `RESP_OKAY;
      if (aw_addr_r == `CTRL_OFS) begin
        if (w_strb_r) begin
          ar_en_nxt = w_data_r[`CTRL_AR_BIT];
        end
      end else if (aw_addr_r != `STAT_OFS) begin
        bresp_nxt = `RESP_SLVERR;
      end
    end
    awrdy_nxt  = ~aw_hold_nxt & ~bvalid_nxt;
    wrdy_nxt   = ~w_hold_nxt & ~bvalid_nxt;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && RREADY_I) begin
      rvalid_nxt = 1'b0;
    end
    if (ARVALID_I && arrdy_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `RESP_OKAY;
      rdata_nxt  = 32'h00000000;
      if (ARADDR_I == `CTRL_OFS) begin
        rdata_nxt[`CTRL_AR_BIT] = ar_en_r;
      end else if (ARADDR_I == `STAT_OFS) begin
        rdata_nxt = stat_word;
      end else begin
        rresp_nxt = `RESP_SLVERR;
      end
    end
    arrdy_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      awrdy_r   <= 1'b0;
      wrdy_r    <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
      ar_en_r   <= `CTRL_RST;
      arrdy_r   <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= `RESP_OKAY;
    end else begin
      awrdy_r   <= awrdy_nxt;
      wrdy_r    <= wrdy_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      ar_en_r   <= ar_en_nxt;
      arrdy_r   <= arrdy_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  assign AWREADY_O = awrdy_r;
  assign WREADY_O  = wrdy_r;
  assign BVALID_O  = bvalid_r;
  assign BRESP_O   = bresp_r;
  assign ARREADY_O = arrdy_r;
  assign RVALID_O  = rvalid_r;
  assign RDATA_O   = rdata_r;
  assign RRESP_O   = rresp_r;

endmodule

// [rtl/osc_if.sv]
// Oscillator to control logic signals
`timescale 1ns/1ns
interface osc_if;
  logic cycle_start;
  logic max_duty_window;

  modport osc (output cycle_start, output max_duty_window);
  modport ctl (input cycle_start, input max_duty_window);
endinterface
